// file: cfm_pkg.sv
// Package for the contactor feedback monitor: sizes, timing and states
package cfm_pkg;
	// Instances handled by one monitor block
	localparam int NUM_CH = 32;
	// Controller logic cycle and clock
	localparam int CLK_HZ = 40_000_000;
	localparam int LOGIC_CYCLE_NS = 10_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CYCLE_CLKS = (LOGIC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 9;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLE_CLKS - 1);
	// Feedback window, in logic cycles
	localparam int WIN_W = 16;
	localparam logic [WIN_W-1:0] WIN_ZERO = 16'h0000;
	localparam logic [WIN_W-1:0] WIN_ONE = 16'h0001;
	// Indicator flash half period (phase toggles every 50), in logic cycles
	localparam int FLASH_W = 6;
	localparam logic [FLASH_W-1:0] FLASH_LAST = 6'h31;
	// Register byte offsets
	localparam logic [4:0] ADDR_STATUS = 5'h00;
	localparam logic [4:0] ADDR_MASK   = 5'h04;
	localparam logic [4:0] ADDR_FAULT  = 5'h08;
	typedef enum logic [1:0] {
		CFM_SETTLED,
		CFM_WAITING,
		CFM_FAULT
	} cfm_state_t;
endpackage : cfm_pkg

// file: cfm_monitor.sv
// Contactor feedback monitor: checks feedback against output level per channel
//
// Contract
// - output high needs feedback low, output low needs feedback high, within window.
// - missed window forces output low and flashes the channel clear indicator.
// - enabled fault flag goes high on feedback timing error, low otherwise.
// - window length is a configurable per-channel value in logic cycles.
// - clear input acts only while its enable option is selected.
// - high enabled clear removes latched error without any controller reset.
// - feedback comes from an ordinary input, synchronised before use.
// - thirty-two independent monitor channels.
`timescale 1ns/1ps
module cfm_monitor
	import cfm_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	input  wire logic                          clkEn,
	// Requested safety level per channel, from logic
	input  wire logic [cfm_pkg::NUM_CH-1:0]    demand,
	// Contactor feedback pins per channel
	input  wire logic [cfm_pkg::NUM_CH-1:0]    feedbackPin,
	// Configuration per channel
	input  wire logic [cfm_pkg::NUM_CH*cfm_pkg::WIN_W-1:0] windowCycles,
	input  wire logic [cfm_pkg::NUM_CH-1:0]    clearEnable,
	input  wire logic [cfm_pkg::NUM_CH-1:0]    errorOutEnable,
	// Clear pins per channel
	input  wire logic [cfm_pkg::NUM_CH-1:0]    clearPin,
	// Results per channel
	output logic      [cfm_pkg::NUM_CH-1:0]    safetyOut,
	output logic      [cfm_pkg::NUM_CH-1:0]    faultFlag,
	output logic      [cfm_pkg::NUM_CH-1:0]    clearLed,
	// Interrupt registers
	input  wire logic [4:0]                    regAddr,
	input  wire logic [31:0]                   regWdata,
	input  wire logic                          regWr,
	input  wire logic                          regRd,
	output logic      [31:0]                   regRdata,
	output logic                               irq
);
	import cfm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [NUM_CH-1:0] fbMeta;
	logic [NUM_CH-1:0] fbSync;
	logic [NUM_CH-1:0] clrMeta;
	logic [NUM_CH-1:0] clrSync;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fbMeta  <= '1;
			fbSync  <= '1;
			clrMeta <= '0;
			clrSync <= '0;
		end else if (clkEn) begin
			fbMeta  <= feedbackPin;
			fbSync  <= fbMeta;
			clrMeta <= clearPin;
			clrSync <= clrMeta;
		end
	end

	syncStage_a: assert property (@(posedge clk) disable iff (!arst_n)
		clkEn |=> fbSync == $past(fbMeta))
		else $error("feedback skipped a sync stage");

	syncClear_a: assert property (@(posedge clk) disable iff (!arst_n)
		clkEn |=> clrSync == $past(clrMeta))
		else $error("clear skipped a sync stage");

	////////////////////////////////////////////////////////////////////////////
	// Logic cycle tick
	logic [TICK_W-1:0]  tickCnt;
	logic               tick;
	logic [FLASH_W-1:0] flashCnt;
	logic               flashPhase;

	assign tick = (tickCnt == TICK_LAST);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt <= '0;
		end else if (clkEn) begin
			tickCnt <= tick ? '0 : tickCnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flashCnt   <= '0;
			flashPhase <= 1'b0;
		end else if (clkEn && tick) begin
			if (flashCnt == FLASH_LAST) begin
				flashCnt   <= '0;
				flashPhase <= ~flashPhase;
			end else begin
				flashCnt <= flashCnt + 1'b1;
			end
		end
	end

	tickOnce_a: assert property (@(posedge clk) disable iff (!arst_n)
		clkEn && tick |=> !tick)
		else $error("logic cycle tick lasted two clocks");

	flashSteady_a: assert property (@(posedge clk) disable iff (!arst_n)
		clkEn && !tick |=> flashPhase == $past(flashPhase))
		else $error("flash phase moved between ticks");

	////////////////////////////////////////////////////////////////////////////
	// Channels
	logic [NUM_CH-1:0] errEvent;
	logic [NUM_CH-1:0] faulted;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gCh
			cfm_state_t        state;
			logic [WIN_W-1:0]  waitCnt;
			logic              lastDemand;
			logic [WIN_W-1:0]  win;
			logic              fbGood;
			logic              clrReq;

			assign win    = windowCycles[g*WIN_W +: WIN_W];
			assign fbGood = (fbSync[g] == ~lastDemand);
			assign clrReq = clearEnable[g] & clrSync[g];

			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					state       <= CFM_SETTLED;
					waitCnt     <= WIN_ZERO;
					lastDemand  <= 1'b0;
					errEvent[g] <= 1'b0;
				end else if (clkEn) begin
					errEvent[g] <= 1'b0;
					if (tick) begin
						case (state)
							CFM_SETTLED: begin
								if (demand[g] != lastDemand) begin
									lastDemand <= demand[g];
									waitCnt    <= WIN_ZERO;
									state      <= CFM_WAITING;
								end else if (!fbGood) begin
									waitCnt <= WIN_ZERO;
									state   <= CFM_WAITING;
								end
							end
							CFM_WAITING: begin
								if (demand[g] != lastDemand) begin
									lastDemand <= demand[g];
									waitCnt    <= WIN_ZERO;
								end else if (fbGood) begin
									state <= CFM_SETTLED;
								end else if (waitCnt + WIN_ONE >= win) begin
									state       <= CFM_FAULT;
									errEvent[g] <= 1'b1;
								end else begin
									waitCnt <= waitCnt + WIN_ONE;
								end
							end
							CFM_FAULT: begin
								if (clrReq) begin
									lastDemand <= 1'b0;
									waitCnt    <= WIN_ZERO;
									state      <= CFM_WAITING;
								end
							end
							default: state <= CFM_SETTLED;
						endcase
					end
				end
			end

			assign faulted[g] = (state == CFM_FAULT);

			// Single downstream block relies on this gating
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					safetyOut[g] <= 1'b0;
				end else if (clkEn) begin
					safetyOut[g] <= demand[g] & ~faulted[g];
				end
			end

			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					faultFlag[g] <= 1'b0;
				end else if (clkEn) begin
					faultFlag[g] <= errorOutEnable[g] & faulted[g];
				end
			end

			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					clearLed[g] <= 1'b0;
				end else if (clkEn) begin
					clearLed[g] <= faulted[g] & flashPhase;
				end
			end

			// Fault outcome checks
			faultHold_a: assert property (@(posedge clk) disable iff (!arst_n)
				faulted[g] && !clrReq |=> faulted[g])
				else $error("fault left without clear");

			outLow_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && faulted[g] |=> !safetyOut[g])
				else $error("output high during fault");

			outFollow_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && !faulted[g] |=> safetyOut[g] == $past(demand[g]))
				else $error("healthy output did not follow demand");

			flagFollow_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn |=> faultFlag[g] == $past(errorOutEnable[g] & faulted[g]))
				else $error("fault flag mismatch");

			flagOn_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && faulted[g] && errorOutEnable[g] |=> faultFlag[g])
				else $error("enabled fault flag stayed low");

			flagOff_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && !errorOutEnable[g] |=> !faultFlag[g])
				else $error("disabled fault flag went high");

			ledOff_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && !faulted[g] |=> !clearLed[g])
				else $error("clear indicator lit without fault");

			// Window checks
			winBound_a: assert property (@(posedge clk) disable iff (!arst_n)
				state == CFM_WAITING && win != WIN_ZERO |-> waitCnt < win)
				else $error("window counter ran past window");

			goodNoFault_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && tick && state == CFM_WAITING && fbGood
				&& demand[g] == lastDemand |=> !faulted[g])
				else $error("fault despite correct feedback");

			settleCheck_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && tick && state == CFM_SETTLED && !fbGood
				&& demand[g] == lastDemand |=> state == CFM_WAITING)
				else $error("wrong feedback did not open window");

			faultTick_a: assert property (@(posedge clk) disable iff (!arst_n)
				!faulted[g] && !(clkEn && tick) |=> !faulted[g])
				else $error("fault outside enabled cycle");

			faultCause_a: assert property (@(posedge clk) disable iff (!arst_n)
				$rose(faulted[g]) |-> errEvent[g])
				else $error("fault without timing error");

			errTick_a: assert property (@(posedge clk) disable iff (!arst_n)
				errEvent[g] && $past(clkEn) |-> $past(tick))
				else $error("error outside logic cycle");

			errSingle_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && errEvent[g] |=> !errEvent[g])
				else $error("error event longer than one clock");

			// Clear checks
			clearGate_a: assert property (@(posedge clk) disable iff (!arst_n)
				faulted[g] && !clearEnable[g] |=> faulted[g])
				else $error("clear acted while disabled");

			clearWorks_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && tick && faulted[g] && clrReq |=> !faulted[g])
				else $error("clear did not remove fault");

			clearRestart_a: assert property (@(posedge clk) disable iff (!arst_n)
				clkEn && tick && faulted[g] && clrReq |=> state == CFM_WAITING
				&& waitCnt == WIN_ZERO)
				else $error("clear did not restart the window");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and readback
	logic [NUM_CH-1:0] irqStatus;
	logic [NUM_CH-1:0] irqMask;
	logic              statusRead;

	assign statusRead = regRd && (regAddr == ADDR_STATUS);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqStatus <= '0;
		end else if (clkEn) begin
			// Set wins over read clear
			irqStatus <= (statusRead ? '0 : irqStatus) | errEvent;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqMask <= '0;
		end else if (clkEn && regWr && regAddr == ADDR_MASK) begin
			irqMask <= regWdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= '0;
		end else if (clkEn) begin
			regRdata <= '0;
			if (regRd) begin
				case (regAddr)
					ADDR_STATUS: regRdata <= irqStatus;
					ADDR_MASK:   regRdata <= irqMask;
					ADDR_FAULT:  regRdata <= faulted;
					default:     regRdata <= '0;
				endcase
			end
		end
	end

	assign irq = |(irqStatus & irqMask);

	// Register side checks
	statusSet_a: assert property (@(posedge clk) disable iff (!arst_n)
		clkEn && (|errEvent) |=> (irqStatus & $past(errEvent)) == $past(errEvent))
		else $error("error event lost from status");

	statusClr_a: assert property (@(posedge clk) disable iff (!arst_n)
		clkEn && statusRead && !(|errEvent) |=> irqStatus == '0)
		else $error("status read did not clear");

	maskWrite_a: assert property (@(posedge clk) disable iff (!arst_n)
		clkEn && regWr && regAddr == ADDR_MASK |=> irqMask == $past(regWdata))
		else $error("mask write did not land");

	readIdle_a: assert property (@(posedge clk) disable iff (!arst_n)
		clkEn && !regRd |=> regRdata == '0)
		else $error("read data without read strobe");

	irqOff_a: assert property (@(posedge clk) disable iff (!arst_n)
		irqMask == '0 |-> !irq)
		else $error("interrupt with all sources masked");

endmodule : cfm_monitor

// file: cfm_contactor_model.sv
// Contactor model: feedback contact opens while the coil is energised
`timescale 1ns/1ps
module cfm_contactor_model
	import cfm_pkg::*;
#(
	parameter int DROP_CLKS = 160
)(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	// Coil drive and forced welds
	input  wire logic [cfm_pkg::NUM_CH-1:0] coil,
	input  wire logic [cfm_pkg::NUM_CH-1:0] stuck,
	// Feedback contacts
	output logic      [cfm_pkg::NUM_CH-1:0] feedback
);
	import cfm_pkg::*;

	int cnt;
	////////////////////////////////////////////////////////////
	// Contacts follow the coil inverted after the drop delay; welded ones hold
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt      <= 0;
			feedback <= '1;
		end else if (cnt == DROP_CLKS - 1) begin
			cnt      <= 0;
			feedback <= (feedback & stuck) | (~coil & ~stuck);
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : cfm_contactor_model

// file: cfm_monitor_tb.sv
// Testbench for the contactor feedback monitor
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
	$display("wrong value %s exp %0h got %0h", nm, e, a); end end
module cfm_monitor_tb;
	import cfm_pkg::*;
	logic                    clk = 0, arst_n = 0, clkEn = 1, regWr = 0, regRd = 0, irq, a;
	logic [NUM_CH-1:0]       demand = '0, clearEnable = '0, clearPin = '0, stuck = '0;
	logic [NUM_CH-1:0]       errorOutEnable = 32'hFFFFFFFB;
	logic [NUM_CH-1:0]       feedbackPin, safetyOut, faultFlag, clearLed;
	logic [NUM_CH*WIN_W-1:0] windowCycles = {{29{16'h0003}}, 16'h0002, 16'h0002, 16'h0004};
	logic [4:0]              regAddr = '0;
	logic [31:0]             regWdata = '0, regRdata, d;
	int                      n_errors = 0, n_compared = 0;
	always #12.5 clk = ~clk;
	cfm_monitor dut (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .demand(demand),
		.feedbackPin(feedbackPin), .windowCycles(windowCycles), .clearEnable(clearEnable),
		.errorOutEnable(errorOutEnable), .clearPin(clearPin), .safetyOut(safetyOut),
		.faultFlag(faultFlag), .clearLed(clearLed), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
	cfm_contactor_model contactors (.clk(clk), .arst_n(arst_n), .coil(safetyOut),
		.stuck(stuck), .feedback(feedbackPin));
	////////////////////////////////////////////////////////////
	task automatic lc(input int n);
		repeat (n * CYCLE_CLKS) @(posedge clk);
		#1;
	endtask : lc
	task automatic wr(input logic [4:0] ad, input logic [31:0] v);
		@(posedge clk);
		regWr <= 1; regAddr <= ad; regWdata <= v;
		@(posedge clk);
		regWr <= 0;
		#1;
	endtask : wr
	task automatic rd(input logic [4:0] ad);
		@(posedge clk);
		regRd <= 1; regAddr <= ad;
		@(posedge clk);
		regRd <= 0;
		#1 d = regRdata;
	endtask : rd
	task automatic test_done;
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////
	task automatic t_good;
		@(posedge clk);
		demand[0] <= 1;
		lc(8);
		`CHK("safetyOut0", 1'b1, safetyOut[0])
		`CHK("faultFlag0", 1'b0, faultFlag[0])
		@(posedge clk);
		demand[0] <= 0;
		lc(8);
		`CHK("low pair", 2'b00, {safetyOut[0], faultFlag[0]})
	endtask : t_good
	task automatic t_fault;
		@(posedge clk);
		stuck[2:1] <= 2'b11;
		demand[2:1] <= 2'b11;
		lc(6);
		`CHK("safetyOut12", 2'b00, safetyOut[2:1])
		`CHK("faultFlag12", 2'b01, faultFlag[2:1])
		a = clearLed[1];
		@(posedge clk);
		stuck[2:1] <= 2'b00;
		lc(51);
		`CHK("clearLed1", ~a, clearLed[1])
		`CHK("held fault", 3'b010, {safetyOut[1], faultFlag[1], clearLed[0]})
		wr(5'h04, 32'h00000002);
		`CHK("irq on", 1'b1, irq)
		rd(5'h00);
		`CHK("status", 32'h00000006, d)
		`CHK("irq off", 1'b0, irq)
		rd(5'h08);
		`CHK("fault state", 32'h00000006, d)
		rd(5'h0C);
		`CHK("unmapped", 32'h00000000, d)
	endtask : t_fault
	task automatic t_clear;
		@(posedge clk);
		clearPin[2:1] <= 2'b11;
		lc(4);
		`CHK("clear off", 1'b1, faultFlag[1])
		@(posedge clk);
		clearEnable[1] <= 1;
		lc(4);
		@(posedge clk);
		clearPin[2:1] <= 2'b00;
		lc(4);
		`CHK("cleared", 2'b10, {safetyOut[1], faultFlag[1]})
		`CHK("no clear", 1'b0, safetyOut[2])
	endtask : t_clear
	task automatic t_freeze;
		@(posedge clk);
		clkEn <= 0;
		demand[3] <= 1;
		lc(2);
		`CHK("frozen out", 1'b0, safetyOut[3])
		@(posedge clk);
		clkEn <= 1;
		lc(4);
		`CHK("thawed", 2'b10, {safetyOut[3], faultFlag[3]})
	endtask : t_freeze
	////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		#1;
		`CHK("reset out", 1'b0, safetyOut[0] | faultFlag[0] | irq)
		@(posedge clk);
		arst_n <= 1;
		t_good();
		t_fault();
		t_clear();
		t_freeze();
		test_done();
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		test_done();
	end
endmodule : cfm_monitor_tb
